// ---- tb/rpw_core_model.sv ----
// Purpose: core data bus model issuing one access per cycle
// Assumes: tasks entered 1 ns after a rising edge
// Notes:   request held until the taking edge
module rpw_core_model
   import rpw_pkg::*;
(
   input  wire logic     i_mclk,
   output rpw_sel_strb_t o_sel,
   output rpw_acc_t      o_acc
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_acc = '0;
      o_sel = '0;
   end
   task automatic put(input logic [4:0] s, input logic [1:0] wr_rd,
                      input logic [1:0] be, input logic [15:0] d);
      o_acc = {wr_rd, be, d};
      o_sel = rpw_sel_strb_t'(s);
      @(posedge i_mclk);
      #1;
   endtask
   task automatic idle();
      put(5'h00, 2'h0, 2'h0, 16'h0000);
   endtask
   // a gap cycle breaks the key sequence
   task automatic unlock(input logic gap, input logic [15:0] cfg);
      put(5'h01, 2'h2, 2'h1, 16'h0055);
      if (gap)
         idle();
      put(5'h01, 2'h2, 2'h1, 16'h00aa);
      put(5'h10, 2'h2, 2'h3, cfg);
   endtask
endmodule

// ---- tb/rpw_window_assertions.sv ----
// Purpose: pointer stepping, window map and write lock checks
// Assumes: one clock, sync active-high reset
// Notes:   bound to rpw_window
module rpw_window_chk
   import rpw_pkg::*;
(
   input wire logic          i_mclk,
   input wire logic          i_sys_rst,
   input wire rpw_acc_t      i_acc,
   input wire rpw_sel_strb_t i_sel,
   input wire logic [15:0]   o_rdata,
   input wire logic [1:0]    o_time_ptr,
   input wire logic [1:0]    o_alarm_ptr,
   input wire logic          o_time_write_enable,
   input wire logic [7:0]    o_time_fields [7]
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   function automatic logic [1:0] dec(input logic [1:0] p);
      return (p == 2'h0) ? p : p - 2'h1;
   endfunction
   logic tr, ar, tw, aw;
   assign tr = i_acc.rd && i_sel.tval;
   assign ar = i_acc.rd && i_sel.aval;
   assign tw = i_acc.wr && i_sel.tval;
   assign aw = i_acc.wr && i_sel.aval && i_acc.be[1];
   chk_tptr_read:
      assert property (tr |=> o_time_ptr == dec($past(o_time_ptr)))
      else $error("time ptr read step");
   chk_tptr_write:
      assert property (tw && i_acc.be[1] |=>
         o_time_ptr == dec($past(o_time_ptr)))
      else $error("time ptr write step");
   chk_aptr_read:
      assert property (ar |=> o_alarm_ptr == dec($past(o_alarm_ptr)))
      else $error("alarm ptr read step");
   chk_aptr_write:
      assert property (aw |=> o_alarm_ptr == dec($past(o_alarm_ptr)))
      else $error("alarm ptr write step");
   chk_lock_hold:
      assert property (tw && !o_time_write_enable |=>
         $stable(o_time_fields[1]) && $stable(o_time_fields[0]))
      else $error("locked write landed");
   chk_unlock_seq:
      assert property ($rose(o_time_write_enable) |->
         $past(i_acc.wdata[7:0], 2) == KEY_SECOND && $past(i_sel.key, 2)
         && $past(i_acc.wdata[7:0], 3) == KEY_FIRST && $past(i_sel.key, 3))
      else $error("enable without unlock");
   chk_time_map:
      assert property (tr && o_time_ptr == 2'h2 |=>
         o_rdata == {o_time_fields[5], o_time_fields[4]})
      else $error("month/day lane");
   chk_alarm_none:
      assert property (ar && o_alarm_ptr == 2'h3 |=> o_rdata == 16'h0000)
      else $error("alarm ptr 3 not zero");
   cover property ($rose(o_time_write_enable));
   cover property (tw && o_time_write_enable);
   cover property (ar && o_alarm_ptr == 2'h3);
endmodule
bind rpw_window rpw_window_chk u_chk (.*);

// ---- tb/rtc_pointer_window_and_write_lock_bench.sv ----
// Purpose: self-checking bench for the pointer window block
// Assumes: 10 MHz clock, reset held 10 cycles
// Notes:   accesses come from the core bus model
module rtc_pointer_window_and_write_lock_bench
   import rpw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic          i_mclk = 1'b0;
   logic          i_sys_rst = 1'b1;
   rpw_acc_t      acc;
   rpw_sel_strb_t sel;
   logic [15:0]   rdata;
   logic [1:0]    tptr, aptr;
   logic          wen;
   logic [7:0]    tfld [7];
   logic [7:0]    afld [6];
   int            failures = 0;
   int            checked = 0;
   always #50 i_mclk = ~i_mclk;
   rpw_core_model core (.i_mclk(i_mclk), .o_sel(sel), .o_acc(acc));
   rpw_window DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_acc(acc),
      .i_sel(sel), .o_rdata(rdata), .o_time_ptr(tptr), .o_alarm_ptr(aptr),
      .o_time_write_enable(wen), .o_time_fields(tfld),
      .o_alarm_fields(afld));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // read a window, then check data and stepped pointer
   task automatic rd(input logic [4:0] s, input logic [15:0] exp,
                     input logic [1:0] ptr);
      core.put(s, 2'h1, 2'h3, 16'h0000);
      cmp(rdata, exp);
      cmp(16'(s[1] ? aptr : tptr), 16'(ptr));
   endtask
   task automatic s_lock();
      core.unlock(1'b1, 16'h2000);
      cmp(16'(wen), 16'h0000);
      core.put(5'h08, 2'h2, 2'h3, 16'h1234);
      rd(5'h08, 16'h0000, 2'h0);
      // enable set one cycle too late after the keys
      core.put(5'h01, 2'h2, 2'h1, 16'h0055);
      core.put(5'h01, 2'h2, 2'h1, 16'h00aa);
      core.idle();
      core.put(5'h10, 2'h2, 2'h3, 16'h2000);
      cmp(16'(wen), 16'h0000);
   endtask
   task automatic s_time();
      core.unlock(1'b0, 16'h2300);
      cmp(16'(wen), 16'h0001);
      core.put(5'h08, 2'h2, 2'h3, 16'h1234);
      core.put(5'h08, 2'h2, 2'h3, 16'h0506);
      core.put(5'h08, 2'h2, 2'h1, 16'h0099);
      cmp(16'(tfld[2]), 16'h0099);
      cmp(16'(tptr), 16'h0001);
      core.put(5'h08, 2'h2, 2'h3, 16'h0708);
      core.put(5'h08, 2'h2, 2'h3, 16'h090a);
      cmp(16'(tptr), 16'h0000);
      core.put(5'h10, 2'h2, 2'h3, 16'h0300);
      rd(5'h08, 16'h0034, 2'h2);
      rd(5'h08, 16'h0506, 2'h1);
      rd(5'h08, 16'h0708, 2'h0);
      rd(5'h08, 16'h090a, 2'h0);
   endtask
   task automatic s_alarm();
      core.put(5'h04, 2'h2, 2'h3, 16'h0200);
      core.put(5'h02, 2'h2, 2'h1, 16'h0011);
      cmp(16'(afld[4]), 16'h0011);
      cmp(16'(aptr), 16'h0002);
      core.put(5'h02, 2'h2, 2'h3, 16'h2233);
      core.put(5'h02, 2'h2, 2'h3, 16'h4455);
      core.put(5'h02, 2'h2, 2'h3, 16'h6677);
      core.put(5'h04, 2'h2, 2'h3, 16'h0300);
      core.put(5'h02, 2'h2, 2'h3, 16'heeee);
      core.put(5'h04, 2'h2, 2'h3, 16'h0300);
      rd(5'h02, 16'h0000, 2'h2);
      rd(5'h02, 16'h2233, 2'h1);
      rd(5'h02, 16'h4455, 2'h0);
      rd(5'h02, 16'h6677, 2'h0);
      core.idle();
   endtask
   initial begin
      repeat (10) @(posedge i_mclk);
      #1;
      i_sys_rst = 1'b0;
      s_lock();
      s_time();
      s_alarm();
      conclude();
   end
   // tests take under 100 cycles; allow 2000
   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule

// ---- verilog/rpw_pkg.sv ----
// Purpose: shared constants and carriers for the calendar clock window block
// Assumes: 16-bit core data bus, byte strobes, one clock
// Notes:   register selects are one-hot strobes from the core decoder
package rpw_pkg;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PTR_LSB = 8;
   localparam int PTR_MSB = 9;
   localparam int WREN_BIT = 13;
   // ---------------------------------------------------------------
   // key values and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [7:0] FIELD_RST = 8'h00;
   localparam logic [1:0] PTR_ZERO = 2'h0;
   // cycles allowed between key completion and enable set
   localparam int UNLOCK_WIN_CYC = 1;

   typedef enum logic [1:0] {
      RPW_SEL_MINSEC,
      RPW_SEL_WDHR,
      RPW_SEL_MODAY,
      RPW_SEL_YEAR
   } rpw_sel_t;

   // one core bus access
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  be;    // bit1 high byte, bit0 low byte
      logic [15:0] wdata;
   } rpw_acc_t;

   // register selects of one access
   typedef struct packed {
      logic cfg;
      logic tval;
      logic acfg;
      logic aval;
      logic key;
   } rpw_sel_strb_t;
endpackage

// ---- verilog/rpw_window.sv ----
// Purpose: pointer windows onto time and alarm fields, with write lock
// Assumes: one access per cycle; read data registered one cycle later
// Notes:   time fields are held here; the tick logic loads them elsewhere
//
// Functional notes
// RQ1 - time pointer is config bits 9 to 8
// RQ2 - time map: min/sec, wd/hr, mon/day, year
// RQ3 - time high-byte write decrements pointer, stops at zero
// RQ4 - at zero, stays minutes/seconds until reloaded
// RQ5 - alarm pointer is alarm config bits 9 to 8
// RQ6 - alarm map: min/sec, wd/hr, mon/day, none
// RQ7 - alarm high-byte write decrements, holds at zero
// RQ8 - any alarm window read decrements alarm pointer
// RQ9 - any time window read decrements time pointer
// RQ10 - time writes blocked unless write enable set
// RQ11 - enable set only one cycle after unlock
// RQ12 - software writes 55h, AAh, then sets enable
// RQ13 - software keeps enable clear when idle
// RQ14 - unmapped window lanes read zero, ignore writes
module rpw_window
   import rpw_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic          i_sys_rst,
   input  wire rpw_acc_t      i_acc,
   input  wire rpw_sel_strb_t i_sel,
   output logic [15:0]        o_rdata,
   output logic [1:0]         o_time_ptr,
   output logic [1:0]         o_alarm_ptr,
   output logic               o_time_write_enable,
   output logic [7:0]         o_time_fields [7],
   output logic [7:0]         o_alarm_fields [6]
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [15:0] clk_cfg_r;
   logic [15:0] alm_cfg_r;
   logic [7:0]  tfield_r [7];   // sec,min,hr,wd,day,mon,year
   logic [7:0]  afield_r [6];   // sec,min,hr,wd,day,mon
   // key sequence progress
   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_GOT_FIRST,
      KEY_OPEN
   } rpw_key_t;
   rpw_key_t    key_state_r;
   rpw_key_t    key_state_nxt;
   logic [15:0] rdata_r;
   logic [1:0]  tptr;
   logic [1:0]  aptr;
   logic        t_wr;
   logic        a_wr;
   logic        t_rd;
   logic        a_rd;
   logic        key_wr;
   logic        key_ok;

   assign tptr = clk_cfg_r[PTR_MSB:PTR_LSB]; // RQ1
   assign aptr = alm_cfg_r[PTR_MSB:PTR_LSB]; // RQ5
   assign t_wr = i_acc.wr && i_sel.tval;
   assign a_wr = i_acc.wr && i_sel.aval;
   assign t_rd = i_acc.rd && i_sel.tval;
   assign a_rd = i_acc.rd && i_sel.aval;
   assign key_wr = i_acc.wr && i_sel.key && i_acc.be[0];
   assign key_ok = (key_state_r == KEY_OPEN);

   // low/high field index for a pointer; 7 means no register
   function automatic logic [2:0] lo_idx(input logic [1:0] p);
      case (p)
         RPW_SEL_MINSEC: lo_idx = 3'd0;
         RPW_SEL_WDHR:   lo_idx = 3'd2;
         RPW_SEL_MODAY:  lo_idx = 3'd4;
         default:        lo_idx = 3'd6;
      endcase
   endfunction

   function automatic logic [2:0] hi_idx(input logic [1:0] p);
      case (p)
         RPW_SEL_MINSEC: hi_idx = 3'd1;
         RPW_SEL_WDHR:   hi_idx = 3'd3;
         RPW_SEL_MODAY:  hi_idx = 3'd5;
         default:        hi_idx = 3'd7;
      endcase
   endfunction

   function automatic logic [1:0] dec_ptr(input logic [1:0] p);
      dec_ptr = (p == PTR_ZERO) ? PTR_ZERO : p - 2'd1;
   endfunction

   // ---------------------------------------------------------------
   // unlock sequence
   // ---------------------------------------------------------------
   // any cycle other than the expected next step drops the sequence
   always_comb begin
      key_state_nxt = KEY_IDLE; // RQ11
      case (key_state_r)
         KEY_GOT_FIRST: begin
            if (key_wr && i_acc.wdata[7:0] == KEY_SECOND) begin
               key_state_nxt = KEY_OPEN;
            end
         end
         default: begin
            key_state_nxt = KEY_IDLE;
         end
      endcase
      // a fresh first key restarts from any state
      if (key_wr && i_acc.wdata[7:0] == KEY_FIRST) begin
         key_state_nxt = KEY_GOT_FIRST;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         key_state_r <= KEY_IDLE;
      end else begin
         key_state_r <= key_state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // clock configuration: pointer and write enable
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         clk_cfg_r <= CFG_RST;
      end else if (i_acc.wr && i_sel.cfg) begin
         if (i_acc.be[0]) begin
            clk_cfg_r[7:0] <= i_acc.wdata[7:0];
         end
         if (i_acc.be[1]) begin
            clk_cfg_r[PTR_MSB:PTR_LSB] <= i_acc.wdata[PTR_MSB:PTR_LSB];
            // clearing always allowed, setting only while unlocked
            clk_cfg_r[WREN_BIT] <= i_acc.wdata[WREN_BIT]
                                   && (clk_cfg_r[WREN_BIT] || key_ok); // RQ11
            clk_cfg_r[15:14] <= i_acc.wdata[15:14];
            clk_cfg_r[12:10] <= i_acc.wdata[12:10];
         end
      end else if ((t_wr && i_acc.be[1]) || t_rd) begin
         clk_cfg_r[PTR_MSB:PTR_LSB] <= dec_ptr(tptr); // RQ3 RQ9 RQ4
      end
   end

   // ---------------------------------------------------------------
   // alarm configuration: pointer
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         alm_cfg_r <= CFG_RST;
      end else if (i_acc.wr && i_sel.acfg) begin
         if (i_acc.be[0]) begin
            alm_cfg_r[7:0] <= i_acc.wdata[7:0];
         end
         if (i_acc.be[1]) begin
            alm_cfg_r[15:8] <= i_acc.wdata[15:8];
         end
      end else if ((a_wr && i_acc.be[1]) || a_rd) begin
         alm_cfg_r[PTR_MSB:PTR_LSB] <= dec_ptr(aptr); // RQ7 RQ8
      end
   end

   // ---------------------------------------------------------------
   // field storage
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_tf
         always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
               tfield_r[g] <= FIELD_RST;
            end else if (t_wr && clk_cfg_r[WREN_BIT]) begin // RQ10
               if (i_acc.be[0] && lo_idx(tptr) == 3'(g)) begin // RQ2
                  tfield_r[g] <= i_acc.wdata[7:0];
               end else if (i_acc.be[1] && hi_idx(tptr) == 3'(g)) begin
                  tfield_r[g] <= i_acc.wdata[15:8]; // RQ14
               end
            end
         end
      end
      for (g = 0; g < 6; g++) begin : g_af
         always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
               afield_r[g] <= FIELD_RST;
            end else if (a_wr) begin
               if (i_acc.be[0] && lo_idx(aptr) == 3'(g)) begin // RQ6
                  afield_r[g] <= i_acc.wdata[7:0];
               end else if (i_acc.be[1] && hi_idx(aptr) == 3'(g)) begin
                  afield_r[g] <= i_acc.wdata[15:8];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   function automatic logic [7:0] tget(input logic [2:0] i);
      tget = (i < 3'd7) ? tfield_r[i] : 8'h00; // RQ14
   endfunction

   function automatic logic [7:0] aget(input logic [2:0] i);
      aget = (i < 3'd6) ? afield_r[i] : 8'h00; // RQ14
   endfunction

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rdata_r <= 16'h0000;
      end else if (t_rd) begin
         rdata_r <= {tget(hi_idx(tptr)), tget(lo_idx(tptr))}; // RQ2
      end else if (a_rd) begin
         rdata_r <= {aget(hi_idx(aptr)), aget(lo_idx(aptr))}; // RQ6
      end else if (i_acc.rd && i_sel.cfg) begin
         rdata_r <= clk_cfg_r;
      end else if (i_acc.rd && i_sel.acfg) begin
         rdata_r <= alm_cfg_r;
      end else if (i_acc.rd) begin
         rdata_r <= 16'h0000;
      end
   end

   assign o_rdata = rdata_r;
   assign o_time_ptr = tptr;
   assign o_alarm_ptr = aptr;
   assign o_time_write_enable = clk_cfg_r[WREN_BIT];
   assign o_time_fields = tfield_r;
   assign o_alarm_fields = afield_r;
endmodule
